// ===== rtl/lmp_pkg.sv
package lmp_pkg;

  // ==========================================================================
  // Frame layout
  localparam logic [7:0] ID_DIAG          = 8'h3C;
  localparam logic [7:0] APP_OPCODE       = 8'h80;
  localparam logic [6:0] OP_TWO_SPEED     = 7'h08;
  localparam logic [6:0] OP_STALL         = 7'h16;
  localparam logic [6:0] OP_MOTOR         = 7'h09;
  localparam logic [6:0] OP_FUSE          = 7'h10;
  localparam logic [3:0] DIAG_LEN         = 4'h8;
  localparam logic [3:0] DIRECT_LEN       = 4'h2;
  localparam logic [7:0] MOTOR_FIXED_MASK = 8'hA2;
  localparam logic [7:0] FUSE_IDX_ONES    = 8'hF8;
  localparam logic [7:0] FILL_FF          = 8'hFF;

  // ==========================================================================
  // Values after reset
  localparam logic [3:0]  RST_NIBBLE = 4'h0;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [3:0]  RST_COUNT  = 4'h0;

  typedef enum logic [2:0] {
    KIND_TWO_SPEED,
    KIND_STALL,
    KIND_MOTOR,
    KIND_FUSE,
    KIND_ABS
  } lmp_kind_type;

  // ==========================================================================
  // Protected identifier: parity bits over the 6-bit identifier
  function automatic logic [7:0] lmp_protect(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction : lmp_protect

  // Sum with end-around carry
  function automatic logic [7:0] lmp_sum_add(input logic [7:0] acc, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction : lmp_sum_add

endpackage : lmp_pkg

// ===== rtl/lmp_link_if.sv
`timescale 1ns/10ps
interface lmp_link_if;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       frame_start;
  logic       frame_end;

  modport host (output byte_valid, output byte_data, output frame_start, output frame_end);
  modport dev  (input byte_valid, input byte_data, input frame_start, input frame_end);
endinterface : lmp_link_if

// ===== rtl/lmp_host_encoder.sv
`timescale 1ns/10ps
module lmp_host_encoder
  import lmp_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  lmp_link_if.host          link,
  input  wire logic         i_req_valid,
  input  wire lmp_kind_type i_req_kind,
  input  wire logic         i_req_broad,
  input  wire logic [6:0]   i_req_addr,
  input  wire logic [39:0]  i_req_fields,
  input  wire logic [5:0]   i_req_direct_id,
  input  wire logic [15:0]  i_req_target,
  input  wire logic         i_move_running,
  output logic              o_req_ready
);

  typedef enum logic {H_IDLE, H_SEND} lmp_hstate_type;

  lmp_hstate_type state;
  logic [7:0]     frm [0:9];
  logic [7:0]     nf [0:9];
  logic [3:0]     last;
  logic [3:0]     idx;
  logic [3:0]     nlen;
  logic [7:0]     keep6;
  logic [7:0]     keep7;
  logic [7:0]     keep8;
  logic [7:0]     sum;

  assign o_req_ready = (state == H_IDLE);

  // ==========================================================================
  // Frame build
  always_comb begin
    sum = 8'h00;
    nlen = DIAG_LEN;
    for (int i = 0; i < 10; i++) begin
      nf[i] = FILL_FF;
    end
    nf[0] = ID_DIAG;
    nf[1] = APP_OPCODE;
    nf[2] = {1'b1, OP_TWO_SPEED};
    nf[3] = {i_req_broad, i_req_addr};
    for (int i = 0; i < 5; i++) begin
      nf[4 + i] = i_req_fields[39 - 8 * i -: 8];
    end
    case (i_req_kind)
      KIND_STALL: begin
        nf[2] = {1'b1, OP_STALL};                                  // see RQ4
      end
      KIND_MOTOR: begin
        nf[2] = {1'b1, OP_MOTOR};                                  // see RQ8
        nf[8] = nf[8] | MOTOR_FIXED_MASK;                          // see RQ11
        if (i_move_running) begin
          nf[6] = keep6;                                           // see RQ10
          nf[7] = keep7;
          nf[8] = keep8 | MOTOR_FIXED_MASK;
        end
      end
      KIND_FUSE: begin
        nf[2] = {1'b1, OP_FUSE};                                   // see RQ12
        nf[4] = nf[4] | FUSE_IDX_ONES;
        nf[6] = FILL_FF;
        nf[7] = FILL_FF;
        nf[8] = FILL_FF;
      end
      KIND_ABS: begin
        nf[0] = lmp_protect(i_req_direct_id);                      // see RQ17
        nf[1] = i_req_target[15:8];                                // see RQ16
        nf[2] = i_req_target[7:0];
        nlen = DIRECT_LEN;
      end
      default: begin
        nf[2] = {1'b1, OP_TWO_SPEED};
      end
    endcase
    for (int i = 1; i < 9; i++) begin
      if (i <= int'(nlen)) begin
        sum = lmp_sum_add(sum, nf[i]);
      end
    end
    nf[nlen + 4'h1] = ~sum;
  end

  // ==========================================================================
  // Sender
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= H_IDLE;
      idx <= RST_COUNT;
      last <= RST_COUNT;
      for (int i = 0; i < 10; i++) begin
        frm[i] <= 8'h00;
      end
    end else begin
      case (state)
        H_IDLE: begin
          if (i_req_valid) begin
            for (int i = 0; i < 10; i++) begin
              frm[i] <= nf[i];
            end
            last <= nlen + 4'h1;
            idx <= RST_COUNT;
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (idx == last) begin
            state <= H_IDLE;
          end
          idx <= idx + 4'h1;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Last motor bytes sent while standing still
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      keep6 <= 8'h00;
      keep7 <= 8'h00;
      keep8 <= 8'h00;
    end else if (i_req_valid && o_req_ready && i_req_kind == KIND_MOTOR && !i_move_running) begin
      keep6 <= nf[6];
      keep7 <= nf[7];
      keep8 <= nf[8];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      link.byte_valid <= 1'b0;
      link.byte_data <= 8'h00;
      link.frame_start <= 1'b0;
      link.frame_end <= 1'b0;
    end else begin
      link.byte_valid <= (state == H_SEND);
      if (state == H_SEND) begin
        link.byte_data <= frm[idx];
      end
      link.frame_start <= (state == H_SEND) && (idx == RST_COUNT);
      link.frame_end <= (state == H_SEND) && (idx == last);
    end
  end

endmodule : lmp_host_encoder

// ===== rtl/lmp_dev_decoder.sv
`timescale 1ns/10ps
// Behaviour
// RQ1 - Broadcast zero starts two-speed referencing everywhere
// RQ2 - Top/low speed codes steer referencing moves
// RQ3 - First target absolute, second distance relative
// RQ4 - Stall config: 0x3C, 0x80, opcode 0x16
// RQ5 - Load when node matches or broadcast zero
// RQ6 - Currents byte4, speed codes byte5
// RQ7 - Stall fields unpacked from bytes 6-8
// RQ8 - Motor config: 0x3C, 0x80, opcode 0x09
// RQ9 - Motor config applies immediately during moves
// RQ10 - Master changes only speeds while moving; the encoder also sends new currents in byte4
// RQ11 - Motor fields: safe target, flags, fixed ones
// RQ12 - Fuse write: index, value, 0xFF filler
// RQ13 - Broadcast zero fuse write on every node
// RQ14 - Absolute position command drives motor target
// RQ15 - Discard position when priority logic refuses
// RQ16 - Direct frame: target high, low, checksum
// RQ17 - Recognise own 6-bit direct identifier
// RQ18 - Referencing sets done; not interrupted
// RQ19 - Foreign node with broadcast one ignored
// RQ20 - Act only after checksum verified
module lmp_dev_decoder
  import lmp_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  lmp_link_if.dev          link,
  input  wire logic [6:0]  i_node_addr,
  input  wire logic [5:0]  i_direct_id,
  input  wire logic        i_abs_accept,
  input  wire logic        i_ref_complete,
  output logic             o_ref_start,
  output logic [3:0]       o_ref_top_speed,
  output logic [3:0]       o_ref_low_speed,
  output logic [15:0]      o_first_target,
  output logic [15:0]      o_second_distance,
  output logic             o_ref_busy,
  output logic             o_ref_done,
  output logic             o_stall_cfg_load,
  output logic             o_motor_cfg_load,
  output logic [3:0]       o_drive_current,
  output logic [3:0]       o_standby_current,
  output logic [3:0]       o_top_speed,
  output logic [3:0]       o_low_speed,
  output logic             o_direction,
  output logic [3:0]       o_ramp_rate,
  output logic [2:0]       o_detect_sample_count,
  output logic [3:0]       o_bemf_abs_limit,
  output logic [3:0]       o_bemf_delta_limit,
  output logic [2:0]       o_fullstep_stall_window,
  output logic             o_ramp_profile_sel,
  output logic [1:0]       o_microstep_resolution,
  output logic             o_full_duty_stall_en,
  output logic             o_chop_jitter_en,
  output logic             o_chop_rate_sel,
  output logic [10:0]      o_safe_target,
  output logic             o_fuse_write,
  output logic [2:0]       o_fuse_byte_index,
  output logic [7:0]       o_fuse_value,
  output logic             o_abs_go,
  output logic [15:0]      o_abs_target
);

  typedef enum logic [1:0] {D_WAIT, D_COLLECT, D_DROP} lmp_dstate_type;

  lmp_dstate_type state;
  logic [7:0]     dbuf [0:7];
  logic [3:0]     cnt;
  logic [3:0]     exp_len;
  logic [7:0]     sum;
  logic           is_diag;
  logic           frame_ok;
  logic           app_ok;
  logic           addr_ok;
  logic [6:0]     opcode;
  logic           hit_two;
  logic           hit_stall;
  logic           hit_motor;
  logic           hit_fuse;
  logic           hit_abs;

  // ==========================================================================
  // Byte collection
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= D_WAIT;
      cnt <= RST_COUNT;
      exp_len <= RST_COUNT;
      sum <= 8'h00;
      is_diag <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        dbuf[i] <= 8'h00;
      end
    end else if (link.byte_valid) begin
      if (link.frame_start) begin
        cnt <= RST_COUNT;
        sum <= 8'h00;
        if (link.byte_data == ID_DIAG) begin
          is_diag <= 1'b1;
          exp_len <= DIAG_LEN;
          state <= D_COLLECT;
        end else if (link.byte_data == lmp_protect(i_direct_id)) begin   // see RQ17
          is_diag <= 1'b0;
          exp_len <= DIRECT_LEN;                                         // see RQ16
          state <= D_COLLECT;
        end else begin
          state <= D_DROP;
        end
      end else begin
        case (state)
          D_COLLECT: begin
            if (link.frame_end) begin
              state <= D_WAIT;
            end else if (cnt < DIAG_LEN) begin
              dbuf[cnt[2:0]] <= link.byte_data;
              sum <= lmp_sum_add(sum, link.byte_data);
              cnt <= cnt + 4'h1;
            end else begin
              state <= D_DROP;
            end
          end
          D_DROP: begin
            if (link.frame_end) begin
              state <= D_WAIT;
            end
          end
          D_WAIT: state <= D_WAIT;
          default: state <= D_WAIT;
        endcase
      end
    end
  end

  // ==========================================================================
  // Frame decode
  always_comb begin
    frame_ok = link.byte_valid && link.frame_end && !link.frame_start && state == D_COLLECT
               && cnt == exp_len && link.byte_data == ~sum;              // see RQ20
    app_ok = is_diag && dbuf[0] == APP_OPCODE && dbuf[1][7];
    opcode = dbuf[1][6:0];
    addr_ok = !dbuf[2][7] || dbuf[2][6:0] == i_node_addr;                // see RQ5 see RQ1 see RQ13 see RQ19
    hit_two = frame_ok && app_ok && addr_ok && opcode == OP_TWO_SPEED;
    hit_stall = frame_ok && app_ok && addr_ok && opcode == OP_STALL;     // see RQ4
    hit_motor = frame_ok && app_ok && addr_ok && opcode == OP_MOTOR;     // see RQ8
    hit_fuse = frame_ok && app_ok && addr_ok && opcode == OP_FUSE
               && (dbuf[3] & FUSE_IDX_ONES) == FUSE_IDX_ONES
               && dbuf[5] == FILL_FF && dbuf[6] == FILL_FF && dbuf[7] == FILL_FF;  // see RQ12
    hit_abs = frame_ok && !is_diag && i_abs_accept && !o_ref_busy;       // see RQ15 see RQ18
  end

  // ==========================================================================
  // Pulses
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ref_start <= 1'b0;
      o_stall_cfg_load <= 1'b0;
      o_motor_cfg_load <= 1'b0;
      o_fuse_write <= 1'b0;
      o_abs_go <= 1'b0;
    end else begin
      o_ref_start <= hit_two;
      o_stall_cfg_load <= hit_stall;
      o_motor_cfg_load <= hit_motor;
      o_fuse_write <= hit_fuse;
      o_abs_go <= hit_abs;                                               // see RQ14
    end
  end

  // ==========================================================================
  // Referencing
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ref_top_speed <= RST_NIBBLE;
      o_ref_low_speed <= RST_NIBBLE;
      o_first_target <= RST_WORD;
      o_second_distance <= RST_WORD;
    end else if (hit_two) begin
      o_ref_top_speed <= dbuf[3][7:4];                                   // see RQ2
      o_ref_low_speed <= dbuf[3][3:0];
      o_first_target <= {dbuf[4], dbuf[5]};                              // see RQ3
      o_second_distance <= {dbuf[6], dbuf[7]};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ref_busy <= 1'b0;
      o_ref_done <= 1'b0;
    end else begin
      if (hit_two) begin
        o_ref_busy <= 1'b1;
      end else if (i_ref_complete) begin
        o_ref_busy <= 1'b0;
      end
      if (i_ref_complete && o_ref_busy) begin
        o_ref_done <= 1'b1;                                              // see RQ18
      end
    end
  end

  // ==========================================================================
  // Motion parameters, shared by stall and motor config
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_drive_current <= RST_NIBBLE;
      o_standby_current <= RST_NIBBLE;
      o_top_speed <= RST_NIBBLE;
      o_low_speed <= RST_NIBBLE;
      o_direction <= 1'b0;
      o_ramp_rate <= RST_NIBBLE;
      o_ramp_profile_sel <= 1'b0;
      o_microstep_resolution <= 2'h0;
      o_chop_jitter_en <= 1'b0;
    end else if (hit_stall || hit_motor) begin                           // see RQ9
      o_drive_current <= dbuf[3][7:4];                                   // see RQ6
      o_standby_current <= dbuf[3][3:0];
      o_top_speed <= dbuf[4][7:4];
      o_low_speed <= dbuf[4][3:0];
      o_direction <= dbuf[5][4];
      o_ramp_rate <= dbuf[5][3:0];
      o_ramp_profile_sel <= dbuf[7][4];
      o_microstep_resolution <= dbuf[7][3:2];
      o_chop_jitter_en <= dbuf[7][0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_detect_sample_count <= 3'h0;
      o_bemf_abs_limit <= RST_NIBBLE;
      o_bemf_delta_limit <= RST_NIBBLE;
      o_fullstep_stall_window <= 3'h0;
      o_full_duty_stall_en <= 1'b0;
    end else if (hit_stall) begin
      o_detect_sample_count <= dbuf[5][7:5];                             // see RQ7
      o_bemf_abs_limit <= dbuf[6][7:4];
      o_bemf_delta_limit <= dbuf[6][3:0];
      o_fullstep_stall_window <= dbuf[7][7:5];
      o_full_duty_stall_en <= dbuf[7][1];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_safe_target <= 11'h000;
      o_chop_rate_sel <= 1'b0;
    end else if (hit_motor) begin
      o_safe_target <= {dbuf[5][7:5], dbuf[6]};                          // see RQ11
      o_chop_rate_sel <= dbuf[7][6];
    end
  end

  // ==========================================================================
  // Fuse write and absolute target
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fuse_byte_index <= 3'h0;
      o_fuse_value <= 8'h00;
      o_abs_target <= RST_WORD;
    end else begin
      if (hit_fuse) begin
        o_fuse_byte_index <= dbuf[3][2:0];
        o_fuse_value <= dbuf[4];
      end
      if (hit_abs) begin
        o_abs_target <= {dbuf[0], dbuf[1]};                              // see RQ16
      end
    end
  end

endmodule : lmp_dev_decoder

// ===== testbench/lmp_link_chk.sv
`timescale 1ns/10ps
module lmp_link_chk
  import lmp_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       frame_start,
  input  wire logic       frame_end
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  // ==========================================================================
  // Framing on the link
  a_start_has_byte: assert property (
    frame_start |-> byte_valid && !frame_end) else $error("frame start without a byte");
  a_diag_app_byte: assert property (
    frame_start && byte_data == ID_DIAG |=> byte_valid && byte_data == APP_OPCODE) else $error("bad app opcode");
  a_diag_op_flag: assert property (
    frame_start && byte_data == ID_DIAG |-> ##2 byte_valid && byte_data[7]) else $error("opcode flag low");
  a_diag_frame_len: assert property (
    frame_start && byte_data == ID_DIAG |=> (byte_valid && !frame_end)[*8] ##1 (byte_valid && frame_end))
    else $error("diag frame length wrong");
  a_direct_frame_len: assert property (
    frame_start && byte_data != ID_DIAG |=> (byte_valid && !frame_end)[*2] ##1 (byte_valid && frame_end))
    else $error("direct frame length wrong");
  a_direct_id_parity: assert property (
    frame_start && byte_data != ID_DIAG |-> byte_data[6] == ^{byte_data[4], byte_data[2:0]}
      && byte_data[7] == ~(^{byte_data[5:3], byte_data[1]})) else $error("identifier parity wrong");
  a_fuse_filler: assert property (
    frame_start && byte_data == ID_DIAG ##2 byte_data == {1'b1, OP_FUSE}
      |-> ##2 byte_data[7:3] == 5'h1F ##2 (byte_data == FILL_FF)[*3]) else $error("fuse frame format wrong");
  a_motor_fixed_ones: assert property (
    frame_start && byte_data == ID_DIAG ##2 byte_data == {1'b1, OP_MOTOR}
      |-> ##6 (byte_data & MOTOR_FIXED_MASK) == MOTOR_FIXED_MASK) else $error("motor fixed bits low");
endmodule : lmp_link_chk

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench
  import lmp_pkg::*;
;
  logic         i_core_clk, i_rstn, i_abs_accept, i_ref_complete, i_req_valid, i_req_broad, i_move_running;
  logic [6:0]   i_node_addr, i_req_addr;
  logic [5:0]   i_direct_id, i_req_direct_id;
  logic [39:0]  i_req_fields;
  logic [15:0]  i_req_target;
  lmp_kind_type i_req_kind;
  logic         o_req_ready, o_ref_start, o_ref_busy, o_ref_done, o_stall_cfg_load, o_motor_cfg_load, o_direction;
  logic         o_ramp_profile_sel, o_full_duty_stall_en, o_chop_jitter_en, o_chop_rate_sel, o_fuse_write, o_abs_go;
  logic [3:0]   o_ref_top_speed, o_ref_low_speed, o_drive_current, o_standby_current, o_top_speed, o_low_speed;
  logic [3:0]   o_ramp_rate, o_bemf_abs_limit, o_bemf_delta_limit;
  logic [2:0]   o_detect_sample_count, o_fullstep_stall_window, o_fuse_byte_index;
  logic [1:0]   o_microstep_resolution;
  logic [7:0]   o_fuse_value;
  logic [10:0]  o_safe_target;
  logic [15:0]  o_first_target, o_second_distance, o_abs_target;
  logic [4:0]   pv;
  int           pc[5];
  int           mismatches, checks, cyc;

  // ==========================================================================
  // Both ends and the link checker
  lmp_link_if lnk();
  lmp_host_encoder i_lmp_host_encoder (.*, .link(lnk.host));
  lmp_dev_decoder  i_lmp_dev_decoder  (.*, .link(lnk.dev));
  lmp_link_chk i_lmp_link_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .byte_valid(lnk.byte_valid),
    .byte_data(lnk.byte_data), .frame_start(lnk.frame_start), .frame_end(lnk.frame_end));

  assign pv = {o_abs_go, o_fuse_write, o_motor_cfg_load, o_stall_cfg_load, o_ref_start};

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // ==========================================================================
  // Pulse counting and timeout
  always @(posedge i_core_clk) begin
    cyc++;
    for (int k = 0; k < 5; k++) if (pv[k] === 1'b1) pc[k]++;
    if (cyc == 2000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(string what, logic [39:0] seen, logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic send(lmp_kind_type k, logic b, logic [6:0] a, logic [39:0] f, logic [15:0] t, logic [5:0] id,
                      logic [4:0] exp);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 50) begin
      @(negedge i_core_clk);
      n++;
    end
    pc = '{default: 0};
    @(posedge i_core_clk);
    i_req_valid     <= 1'b1;
    i_req_kind      <= k;
    i_req_broad     <= b;
    i_req_addr      <= a;
    i_req_fields    <= f;
    i_req_target    <= t;
    i_req_direct_id <= id;
    @(posedge i_core_clk);
    i_req_valid <= 1'b0;
    @(negedge i_core_clk);
    chk("request ready", o_req_ready, 1'b0);
    repeat (14) @(negedge i_core_clk);
    for (int j = 0; j < 5; j++) chk($sformatf("pulse count %0d", j), pc[j], exp[j]);
  endtask : send

  // ==========================================================================
  // Scenarios
  task automatic t_stall();
    send(KIND_STALL, 1'b1, 7'h2A, 40'h5A_C3B7_94E6, 16'h0000, 6'h00, 5'b00010);
    chk("stall currents speeds", {o_drive_current, o_standby_current, o_top_speed, o_low_speed}, 16'h5AC3);
    chk("stall byte6", {o_detect_sample_count, o_direction, o_ramp_rate}, 8'hB7);
    chk("stall byte7", {o_bemf_abs_limit, o_bemf_delta_limit}, 8'h94);
    chk("stall byte8", {o_fullstep_stall_window, o_ramp_profile_sel, o_microstep_resolution, o_full_duty_stall_en,
        o_chop_jitter_en}, 8'hE6);
    $display("test stall done");
  endtask : t_stall

  task automatic t_motor();
    send(KIND_MOTOR, 1'b0, 7'h11, 40'h21_47D3_6C4D, 16'h0000, 6'h00, 5'b00100);
    chk("motor byte6 7", {o_safe_target[10:8], o_direction, o_ramp_rate, o_safe_target[7:0]}, 16'hD36C);
    chk("motor byte8", {o_chop_rate_sel, o_ramp_profile_sel, o_microstep_resolution, o_chop_jitter_en},
        5'b10111);
    chk("stall only kept", {o_detect_sample_count, o_bemf_abs_limit, o_bemf_delta_limit, o_fullstep_stall_window,
        o_full_duty_stall_en}, {3'h5, 8'h94, 3'h7, 1'b1});
    @(posedge i_core_clk);
    i_move_running <= 1'b1;
    send(KIND_MOTOR, 1'b1, 7'h2A, 40'h78_2100_0000, 16'h0000, 6'h00, 5'b00100);
    chk("running speeds", {o_drive_current, o_standby_current, o_top_speed, o_low_speed}, 16'h7821);
    chk("running kept", {o_safe_target, o_direction, o_ramp_rate}, {11'h66C, 1'b1, 4'h3});
    @(posedge i_core_clk);
    i_move_running <= 1'b0;
    send(KIND_STALL, 1'b1, 7'h2B, 40'h11_1111_1111, 16'h0000, 6'h00, 5'b00000);
    chk("foreign ignored", {o_drive_current, o_standby_current, o_top_speed, o_low_speed}, 16'h7821);
    $display("test motor done");
  endtask : t_motor

  task automatic t_fuse();
    send(KIND_FUSE, 1'b0, 7'h55, 40'hFD_9EFF_FFFF, 16'h0000, 6'h00, 5'b01000);
    chk("fuse index value", {o_fuse_byte_index, o_fuse_value}, {3'h5, 8'h9E});
    send(KIND_FUSE, 1'b1, 7'h2B, 40'hFA_11FF_FFFF, 16'h0000, 6'h00, 5'b00000);
    chk("fuse kept", {o_fuse_byte_index, o_fuse_value}, {3'h5, 8'h9E});
    $display("test fuse done");
  endtask : t_fuse

  task automatic t_ref();
    send(KIND_TWO_SPEED, 1'b0, 7'h03, 40'hB4_8123_0FF0, 16'h0000, 6'h00, 5'b00001);
    chk("ref speeds", {o_ref_top_speed, o_ref_low_speed}, 8'hB4);
    chk("ref targets", {o_first_target, o_second_distance}, 32'h8123_0FF0);
    chk("ref busy done", {o_ref_busy, o_ref_done}, 2'b10);
    send(KIND_ABS, 1'b1, 7'h00, 40'h00_0000_0000, 16'h1234, 6'h15, 5'b00000);
    @(posedge i_core_clk);
    i_ref_complete <= 1'b1;
    @(posedge i_core_clk);
    i_ref_complete <= 1'b0;
    @(negedge i_core_clk);
    chk("ref busy done", {o_ref_busy, o_ref_done}, 2'b01);
    $display("test referencing done");
  endtask : t_ref

  task automatic t_abs();
    send(KIND_ABS, 1'b1, 7'h00, 40'h00_0000_0000, 16'hFEDC, 6'h15, 5'b10000);
    chk("abs target", o_abs_target, 16'hFEDC);
    send(KIND_ABS, 1'b1, 7'h00, 40'h00_0000_0000, 16'h0246, 6'h16, 5'b00000);
    @(posedge i_core_clk);
    i_abs_accept <= 1'b0;
    send(KIND_ABS, 1'b1, 7'h00, 40'h00_0000_0000, 16'h0246, 6'h15, 5'b00000);
    chk("abs target kept", o_abs_target, 16'hFEDC);
    @(posedge i_core_clk);
    i_abs_accept <= 1'b1;
    $display("test absolute done");
  endtask : t_abs

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    i_rstn = 1'b0;
    i_abs_accept = 1'b1;
    i_ref_complete = 1'b0;
    i_req_valid = 1'b0;
    i_req_broad = 1'b1;
    i_move_running = 1'b0;
    i_node_addr = 7'h2A;
    i_req_addr = 7'h00;
    i_direct_id = 6'h15;
    i_req_direct_id = 6'h00;
    i_req_fields = 40'h00_0000_0000;
    i_req_target = 16'h0000;
    i_req_kind = KIND_STALL;
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
    t_stall();
    t_motor();
    t_fuse();
    t_ref();
    t_abs();
    wrap_up();
  end
endmodule : testbench
